/* File: rtl/spm_pkg.sv */
// Purpose: shared constants and carriers for the shared pin function mux
// Assumes: fourteen shared pins, indexed as listed below
// Notes:   a set bit in a pin vector refers to the pin at that index
`default_nettype none
package spm_pkg;
  localparam int NPIN = 14;
  // pin indices and group widths
  localparam int IDX_B4  = 0;
  localparam int IDX_F0  = 1;
  localparam int NDATA   = 4;
  localparam int IDX_D0  = 5;
  localparam int NCS     = 6;
  localparam int IDX_E0  = 11;
  localparam int IDX_E1  = 12;
  localparam int IDX_D6  = 13;
  // reset values
  localparam logic [13:0] PER_RST  = 14'h381e;
  localparam logic [13:0] PUR_RST  = 14'h1fff;
  localparam logic [13:0] DIR_RST  = 14'h0000;
  localparam logic [13:0] DOUT_RST = 14'h0000;
  localparam logic        CSEL_RST = 1'b0;
  // pull-up bit with inverted sense (set turns the pull-up off)
  localparam logic [13:0] PUR_INV  = 14'h2000;

  typedef enum logic {SPM_CS_ADDR, SPM_CS_PRESC} spm_clk_sel_t;

  typedef struct packed {
    logic [13:0]  per;
    logic [13:0]  pur;
    logic [13:0]  dir;
    logic [13:0]  dout;
    spm_clk_sel_t clk_sel;
  } spm_cfg_t;

  typedef struct packed {
    logic       bus_drive_hold_bit;
    logic       bus_active;
    logic       address_line_20;
    logic       presc_clk;
    logic [3:0] data_out;
    logic       data_oe;
    logic [5:0] cs_b;
    logic       serial0_tx;
    logic       serial1_tx;
  } spm_per_t;
endpackage : spm_pkg
`default_nettype wire

/* File: rtl/spm_pad_cell.sv */
// Purpose: one shared pin: function select, registered drive, input sync
// Assumes: pad_in is asynchronous to clk
// Notes:   oe_b low means the pin is driven
`default_nettype none
module spm_pad_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // function select and sources
  input  wire logic sel_per,
  input  wire logic per_out,
  input  wire logic per_oe,
  input  wire logic gpio_dir,
  input  wire logic gpio_out,
  input  wire logic pu_on,
  // pin side
  input  wire logic pad_in,
  output var  logic pad_out_q,
  output var  logic pad_oe_b_q,
  output var  logic pad_pu_q,
  output var  logic in_sync_q
);
  logic meta_q;
  wire  out_d  = sel_per ? per_out : gpio_out;
  wire  oe_b_d = sel_per ? ~per_oe : ~gpio_dir;

  // during reset: output off, pull-up on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out_q  <= 1'b0;
      pad_oe_b_q <= 1'b1;
      pad_pu_q   <= 1'b1;
    end else if (ce) begin
      pad_out_q  <= out_d;
      pad_oe_b_q <= oe_b_d;
      pad_pu_q   <= pu_on;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q    <= 1'b0;
      in_sync_q <= 1'b0;
    end else if (ce) begin
      meta_q    <= pad_in;
      in_sync_q <= meta_q;
    end
  end
endmodule // spm_pad_cell
`default_nettype wire

/* File: rtl/spm_pin_mux.sv */
// Purpose: function, drive and pull-up control of the shared pins
// Assumes: cfg_wr is a one-cycle pulse from logic on clk
// Notes:   pad outputs follow their sources one enabled clock later
//
// Contract
// - port B line 4 leaves reset as GPIO input, pull-up on.
// - clearing port B pull-up bit 4 turns its pull-up off.
// - with peripheral enabled, clock select picks address 20 or prescaler.
// - drive bit low and bus idle floats address 20.
// - data lines 7-10 off with pull-up in reset, data bus afterwards.
// - drive bit low and bus idle floats data lines 7-10.
// - clearing port F pull-up bit n turns line n pull-up off.
// - port D lines 0-5 leave reset as GPIO, chip selects optional.
// - drive bit low and bus idle floats chip selects 2-7.
// - clearing port D pull-up bit n turns line n pull-up off.
// - serial 0 transmit off in reset, then serial; bit 0 pull-up.
// - serial 0 receive input in reset, then serial; bit 1 pull-up.
// - serial 1 transmit default; setting port D bit 6 removes pull-up.
// - each GPIO line has its own direction.
`default_nettype none
module spm_pin_mux (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  // configuration
  input  wire logic                cfg_wr,
  input  wire spm_pkg::spm_cfg_t   cfg_wdata,
  output var  spm_pkg::spm_cfg_t   cfg_q,
  // peripheral sources
  input  wire spm_pkg::spm_per_t   per_in,
  output var  logic                serial0_rx,
  // pins
  input  wire logic [13:0]         pad_in,
  output var  logic [13:0]         pad_out,
  output var  logic [13:0]         pad_oe_b,
  output var  logic [13:0]         pad_pu,
  output var  logic [13:0]         gpio_in
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q.per     <= spm_pkg::PER_RST;
      cfg_q.pur     <= spm_pkg::PUR_RST;
      cfg_q.dir     <= spm_pkg::DIR_RST;
      cfg_q.dout    <= spm_pkg::DOUT_RST;
      cfg_q.clk_sel <= spm_pkg::spm_clk_sel_t'(spm_pkg::CSEL_RST);
    end else if (ce && cfg_wr) begin
      cfg_q <= cfg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral drive selection
  function automatic logic pu_from_bit(input logic b, input logic inv);
    pu_from_bit = inv ? ~b : b;
  endfunction

  logic [13:0] per_out_w;
  logic [13:0] per_oe_w;
  logic [13:0] pu_w;
  wire         emi_float = ~per_in.bus_drive_hold_bit & ~per_in.bus_active;
  wire         presc_on  = cfg_q.clk_sel == spm_pkg::SPM_CS_PRESC;

  assign per_out_w[spm_pkg::IDX_B4] =
    presc_on ? per_in.presc_clk : per_in.address_line_20;
  assign per_oe_w[spm_pkg::IDX_B4]  = presc_on | ~emi_float;
  assign per_out_w[spm_pkg::IDX_F0 +: spm_pkg::NDATA] = per_in.data_out;
  assign per_oe_w[spm_pkg::IDX_F0 +: spm_pkg::NDATA] =
    {spm_pkg::NDATA{per_in.data_oe & ~emi_float}};
  assign per_out_w[spm_pkg::IDX_D0 +: spm_pkg::NCS] = per_in.cs_b;
  assign per_oe_w[spm_pkg::IDX_D0 +: spm_pkg::NCS] =
    {spm_pkg::NCS{~emi_float}};
  assign per_out_w[spm_pkg::IDX_E0] = per_in.serial0_tx;
  assign per_oe_w[spm_pkg::IDX_E0]  = 1'b1;
  assign per_out_w[spm_pkg::IDX_E1] = 1'b0;
  assign per_oe_w[spm_pkg::IDX_E1]  = 1'b0;
  assign per_out_w[spm_pkg::IDX_D6] = per_in.serial1_tx;
  assign per_oe_w[spm_pkg::IDX_D6]  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // pad cells
  for (genvar i = 0; i < spm_pkg::NPIN; i++) begin : g_pad
    assign pu_w[i] = pu_from_bit(cfg_q.pur[i], spm_pkg::PUR_INV[i]);
    spm_pad_cell u_pad (
      .clk        (clk),
      .rst_b      (rst_b),
      .ce         (ce),
      .sel_per    (cfg_q.per[i]),
      .per_out    (per_out_w[i]),
      .per_oe     (per_oe_w[i]),
      .gpio_dir   (cfg_q.dir[i]),
      .gpio_out   (cfg_q.dout[i]),
      .pu_on      (pu_w[i]),
      .pad_in     (pad_in[i]),
      .pad_out_q  (pad_out[i]),
      .pad_oe_b_q (pad_oe_b[i]),
      .pad_pu_q   (pad_pu[i]),
      .in_sync_q  (gpio_in[i])
    );
  end

  assign serial0_rx = gpio_in[spm_pkg::IDX_E1];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int B4 = spm_pkg::IDX_B4;
  localparam int F0 = spm_pkg::IDX_F0;
  localparam int D0 = spm_pkg::IDX_D0;
  localparam int E0 = spm_pkg::IDX_E0;
  localparam int E1 = spm_pkg::IDX_E1;
  localparam int D6 = spm_pkg::IDX_D6;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_release;
    $rose(rst_b);
  endsequence
  sequence s_idle_bus;
    ce && !per_in.bus_drive_hold_bit && !per_in.bus_active;
  endsequence

  property p_b4_reset;
    s_release |-> pad_oe_b[B4] && pad_pu[B4] && !cfg_q.per[B4]
                  && !cfg_q.dir[B4];
  endproperty
  a_b4_reset : assert property (p_b4_reset) else $error("b4 reset");

  property p_b4_pu_off;
    (ce && !cfg_q.pur[B4]) |=> !pad_pu[B4];
  endproperty
  a_b4_pu_off : assert property (p_b4_pu_off) else $error("b4 pu");

  property p_b4_presc;
    (ce && cfg_q.per[B4] && presc_on) |=>
      !pad_oe_b[B4] && pad_out[B4] == $past(per_in.presc_clk);
  endproperty
  a_b4_presc : assert property (p_b4_presc) else $error("b4 clk");

  property p_b4_float;
    (s_idle_bus and (cfg_q.per[B4] && !presc_on)) |=> pad_oe_b[B4];
  endproperty
  a_b4_float : assert property (p_b4_float) else $error("a20 float");

  property p_data_reset;
    s_release |-> cfg_q.per[F0 +: 4] == 4'hf && pad_oe_b[F0 +: 4] == 4'hf
                  && pad_pu[F0 +: 4] == 4'hf;
  endproperty
  a_data_reset : assert property (p_data_reset) else $error("data rst");

  property p_data_float;
    (s_idle_bus and cfg_q.per[F0]) |=> pad_oe_b[F0];
  endproperty
  a_data_float : assert property (p_data_float) else $error("data fl");

  property p_f_pu_off;
    (ce && !cfg_q.pur[F0 + 2]) |=> !pad_pu[F0 + 2];
  endproperty
  a_f_pu_off : assert property (p_f_pu_off) else $error("f pu");

  property p_d_reset;
    s_release |-> cfg_q.per[D0 +: 6] == 6'h00;
  endproperty
  a_d_reset : assert property (p_d_reset) else $error("d rst");

  property p_cs_float;
    (s_idle_bus and cfg_q.per[D0 + 3]) |=> pad_oe_b[D0 + 3];
  endproperty
  a_cs_float : assert property (p_cs_float) else $error("cs fl");

  property p_d_pu_off;
    (ce && !cfg_q.pur[D0 + 5]) |=> !pad_pu[D0 + 5];
  endproperty
  a_d_pu_off : assert property (p_d_pu_off) else $error("d pu");

  property p_tx0;
    (ce && cfg_q.per[E0]) |=>
      !pad_oe_b[E0] && pad_out[E0] == $past(per_in.serial0_tx);
  endproperty
  a_tx0 : assert property (p_tx0) else $error("tx0");

  property p_rx0;
    (ce && cfg_q.per[E1]) |=> pad_oe_b[E1] && pad_pu[E1] == $past(cfg_q.pur[E1]);
  endproperty
  a_rx0 : assert property (p_rx0) else $error("rx0");

  property p_d6_pu;
    (ce && cfg_q.pur[D6]) |=> !pad_pu[D6];
  endproperty
  a_d6_pu : assert property (p_d6_pu) else $error("d6 pu");

  property p_gpio_dir;
    (ce && !cfg_q.per[D0 + 1]) |=>
      pad_oe_b[D0 + 1] == !$past(cfg_q.dir[D0 + 1]);
  endproperty
  a_gpio_dir : assert property (p_gpio_dir) else $error("dir");

  property p_per_wins;
    (ce && cfg_q.per[D6] && cfg_q.dir[D6] == 1'b0) |=> !pad_oe_b[D6];
  endproperty
  a_per_wins : assert property (p_per_wins) else $error("per");

  property p_tx1;
    (ce && cfg_q.per[D6]) |=> pad_out[D6] == $past(per_in.serial1_tx);
  endproperty
  a_tx1 : assert property (p_tx1) else $error("tx1");

  property p_gpio_out;
    (ce && !cfg_q.per[D0 + 1]) |=>
      pad_out[D0 + 1] == $past(cfg_q.dout[D0 + 1]);
  endproperty
  a_gpio_out : assert property (p_gpio_out) else $error("gpio out");

  property p_cs_value;
    (ce && cfg_q.per[D0] && !emi_float) |=>
      !pad_oe_b[D0] && pad_out[D0] == $past(per_in.cs_b[0]);
  endproperty
  a_cs_value : assert property (p_cs_value) else $error("cs val");
endmodule // spm_pin_mux
`default_nettype wire

/* File: dv/spm_far_model.sv */
// Purpose: pin-side peers of the shared pins (memory and serial links)
// Assumes: peers yield wherever the mux drives the pin
// Notes:   floating unpulled pins toggle every cycle
`default_nettype none
module spm_far_model (
  // clock
  input  wire logic        clk,
  // mux side
  input  wire logic [13:0] pad_out,
  input  wire logic [13:0] pad_oe_b,
  input  wire logic [13:0] pad_pu,
  // peer drive
  input  wire logic [13:0] peer_val,
  input  wire logic [13:0] peer_en,
  // wire level
  output var  logic [13:0] pad_in,
  output var  logic [13:0] known
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog_q = 1'b0;
  always @(posedge clk) tog_q <= ~tog_q;
  assign known = ~pad_oe_b | peer_en | pad_pu;
  assign pad_in = (~pad_oe_b & pad_out) | (pad_oe_b & peer_en & peer_val)
                | (pad_oe_b & ~peer_en & (pad_pu | {14{tog_q}}));
endmodule // spm_far_model
`default_nettype wire

/* File: dv/test_shared_pin_function_mux.sv */
// Purpose: self-checking bench of the shared pin function mux
// Assumes: pads settle two edges after a config write
// Notes:   random config and peripheral sources from an lfsr
`default_nettype none
module test_shared_pin_function_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, cfg_wr = 1'b0, serial0_rx;
  spm_pkg::spm_cfg_t cfg_wdata = '0, cfg_q, c, rc;
  spm_pkg::spm_per_t per_in = '0, p;
  logic [13:0] pad_in, pad_out, pad_oe_b, pad_pu, gpio_in, known;
  logic [13:0] peer_val = '0, peer_en = '0;
  logic [31:0] seed = 32'h0000_a730;
  int errors = 0, n_compared = 0;
  always #10 clk = ~clk;
  spm_pin_mux dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_q(cfg_q), .per_in(per_in),
    .serial0_rx(serial0_rx), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_b(pad_oe_b), .pad_pu(pad_pu), .gpio_in(gpio_in));
  spm_far_model far_u (.clk(clk), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
    .pad_pu(pad_pu), .peer_val(peer_val), .peer_en(peer_en),
    .pad_in(pad_in), .known(known));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    repeat (7) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [41:0] exp_pads(spm_pkg::spm_cfg_t k,
                                           spm_pkg::spm_per_t s);
    logic fl, ck;
    logic [13:0] po, pd;
    fl = !s.bus_drive_hold_bit && !s.bus_active;
    ck = k.clk_sel == spm_pkg::SPM_CS_PRESC;
    po = {s.serial1_tx, 1'b0, s.serial0_tx, s.cs_b, s.data_out,
          ck ? s.presc_clk : s.address_line_20};
    pd = {3'b101, {6{!fl}}, {4{s.data_oe && !fl}}, ck || !fl};
    return {(k.per & po) | (~k.per & k.dout),
            ~((k.per & pd) | (~k.per & k.dir)), k.pur ^ spm_pkg::PUR_INV};
  endfunction
  task automatic chk(input string n, input logic [56:0] e,
                     input logic [56:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check(input spm_pkg::spm_cfg_t k,
                       input spm_pkg::spm_per_t s);
    logic [41:0] e;
    e = exp_pads(k, s);
    chk("cfg_q", k, cfg_q);
    chk("pad_oe_b", 57'(e[27:14]), 57'(pad_oe_b));
    chk("pad_out", 57'(e[41:28] & ~e[27:14]),
        57'(pad_out & ~e[27:14]));
    chk("pad_pu", 57'(e[13:0]), 57'(pad_pu));
    chk("gpio_in", 57'(pad_in & known), 57'(gpio_in & known));
    chk("serial0_rx", 57'(pad_in[12] & known[12]),
        57'(serial0_rx & known[12]));
  endtask
  task automatic apply(input spm_pkg::spm_cfg_t k,
                       input spm_pkg::spm_per_t s);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= k;
    per_in <= s;
    peer_val <= rnd();
    peer_en <= rnd();
    @(posedge clk);
    cfg_wr <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(k, s);
  endtask
  task automatic finish_test();
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    rc = '{spm_pkg::PER_RST, spm_pkg::PUR_RST, spm_pkg::DIR_RST,
           spm_pkg::DOUT_RST, spm_pkg::SPM_CS_ADDR};
    repeat (10) @(posedge clk);
    #1;
    chk("rst oe_b", 57'h3fff, 57'(pad_oe_b));
    chk("rst pu", 57'h3fff, 57'(pad_pu));
    chk("rst cfg", rc, cfg_q);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(rc, per_in);
    c = rc;
    c.per[4:1] = 4'h0;
    apply(c, spm_pkg::spm_per_t'(rnd()));
    for (int i = 0; i < 10; i++) begin
      c = spm_pkg::spm_cfg_t'({rnd(), rnd()});
      if (i < 8) c.per = 14'h3fff;
      c.clk_sel = spm_pkg::spm_clk_sel_t'(i[2]);
      if (i >= 8) c.pur = {14{i[0]}};
      p = spm_pkg::spm_per_t'(rnd());
      p.bus_drive_hold_bit = i[0];
      p.bus_active = i[1];
      apply(c, p);
    end
    @(posedge clk);
    ce <= 1'b0;
    cfg_wr <= 1'b1;
    cfg_wdata <= ~c;
    @(posedge clk);
    ce <= 1'b1;
    cfg_wr <= 1'b0;
    #1;
    chk("cfg_q ce low", c, cfg_q);
    repeat (30) apply(spm_pkg::spm_cfg_t'({rnd(), rnd()}),
                      spm_pkg::spm_per_t'(rnd()));
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    chk("rerst oe_b", 57'h3fff, 57'(pad_oe_b));
    chk("rerst cfg", rc, cfg_q);
    finish_test();
  end
endmodule // test_shared_pin_function_mux
`default_nettype wire
